/* File: hw/autoneg_regs_pkg.sv */
/*
 * constants for the partner ability, expansion and transmit page registers.
 * assumes a 5-bit management register address and 16-bit data.
 */
package autoneg_regs_pkg;
	localparam logic [4:0] ADDR_PARTNER_ABILITY = 5'h05;
	localparam logic [4:0] ADDR_NEG_EXPANSION = 5'h06;
	localparam logic [4:0] ADDR_NEXT_PAGE_TX = 5'h07;
	localparam int BIT_MORE_PAGES = 15;
	localparam int BIT_ACK = 14;
	localparam int BIT_FAR_FAULT = 13;
	localparam int BIT_MSG_PAGE = 13;
	localparam int BIT_ACK2 = 12;
	localparam int BIT_TOGGLE = 11;
	localparam int BIT_PAUSE = 10;
	localparam int TECH_HI = 9;
	localparam int TECH_LO = 5;
	localparam int SEL_HI = 4;
	localparam int CODE_HI = 10;
	localparam int EXP_PD_FAULT = 4;
	localparam int EXP_PARTNER_NP = 3;
	localparam int EXP_LOCAL_NP = 2;
	localparam int EXP_PAGE_RX = 1;
	localparam int EXP_PARTNER_AN = 0;
	localparam logic [15:0] ABILITY_RESET = 16'h0000;
	localparam logic [15:0] EXPANSION_RESET = 16'h0004;
	localparam logic [15:0] NEXT_PAGE_TX_RESET = 16'h2001;
	localparam logic [15:0] NEXT_PAGE_TX_WMASK = 16'hB7FF;
endpackage

/* File: hw/autoneg_partner_page_regs.sv */
/*
 * partner ability, negotiation expansion and next page transmit registers of one port.
 * assumes the negotiation engine drives single-cycle pulses on the same clock,
 * and a management port with one-cycle read and write strobes.
 */
// Overview of operation
// RULE1: software trusts partner abilities only after negotiation complete reads 1.
// RULE2: ability bit 15 shows partner has more pages to send.
// RULE3: ability bit 14 shows the partner acknowledge bit.
// RULE4: ability bit 13 copies partner far fault; no other action.
// RULE5: ability bit 10 shows partner pause capability.
// RULE6: ability bits 9:5 show partner technologies, cleared on restart or reset.
// RULE7: ability bits 4:0 hold partner selector, cleared on restart or reset.
// RULE8: expansion bit 4 latches parallel detection fault, clears on read or reset.
// RULE9: expansion bit 3 always equals ability bit 15.
// RULE10: expansion bit 2 always reads 1.
// RULE11: expansion bit 1 latches page received until read or reset.
// RULE12: expansion bit 0 latches once partner is known to negotiate.
// RULE13: transmit page bit 15 writable, resets 0, marks more pages.
// RULE14: transmit page bit 13 writable, resets 1, marks message page.
// RULE15: transmit page bit 12 writable, resets 0, compliance flag.
// RULE16: transmit page bit 11 read-only, inverse of last sent toggle.
// RULE17: transmit page bits 10:0 writable code field, reset to 1.
// RULE18: unformatted pages may carry any 11-bit code.
// RULE19: software writes reserved bits with defaults and ignores them on read.
// RULE20: negotiation complete reads 1 only once the registers are valid.
// RULE21: expansion read returns latched flags, then clears them; new events survive.
`timescale 1ns/10ps
module autoneg_partner_page_regs
	import autoneg_regs_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic neg_restart_i,
	input wire logic base_page_rx_i,
	input wire logic [15:0] partner_word_i,
	input wire logic page_rx_i,
	input wire logic partner_neg_able_i,
	input wire logic pd_fault_i,
	input wire logic neg_done_i,
	input wire logic page_sent_i,
	input wire logic sent_toggle_i,
	output logic [15:0] next_page_tx_o,
	output logic neg_complete_o
);
	logic [15:0] partner_ability;
	logic [15:0] next_page_transmit;
	logic pd_fault_flag;
	logic page_rx_flag;
	logic partner_an_flag;
	logic tx_toggle;
	logic exp_read;
	logic [15:0] expansion_view;
	logic [15:0] next_rdata;
	// received page, field by field
	logic partner_more_pages;
	logic partner_ack_flag;
	logic partner_far_fault;
	logic partner_pause_cap;
	logic [4:0] partner_tech;
	logic [4:0] partner_selector;
	// written transmit page fields; bits 14 and 11 are never stored
	logic tx_more_pages;
	logic tx_msg_page;
	logic tx_comply;
	logic [10:0] tx_code;
	logic sel_expansion;
	logic sel_tx;
	logic ability_load;
	logic tx_write;
	logic [15:0] next_tx_word;

	// decodes for the expansion and transmit page registers only: expansion gates the read clear, transmit page the write path
	assign sel_expansion = (reg_addr_i == ADDR_NEG_EXPANSION);
	assign sel_tx = (reg_addr_i == ADDR_NEXT_PAGE_TX);
	assign exp_read = reg_rd_i && sel_expansion;
	assign ability_load = base_page_rx_i || page_rx_i;
	assign tx_write = reg_wr_i && sel_tx;

	// each field reloads from whichever page was just accepted; restart empties them
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			partner_more_pages <= ABILITY_RESET[BIT_MORE_PAGES];
		end else if (neg_restart_i) begin
			partner_more_pages <= ABILITY_RESET[BIT_MORE_PAGES];
		end else if (ability_load) begin
			partner_more_pages <= partner_word_i[BIT_MORE_PAGES]; // [RULE2]
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			partner_ack_flag <= ABILITY_RESET[BIT_ACK];
		end else if (neg_restart_i) begin
			partner_ack_flag <= ABILITY_RESET[BIT_ACK];
		end else if (ability_load) begin
			partner_ack_flag <= partner_word_i[BIT_ACK]; // [RULE3]
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			partner_far_fault <= ABILITY_RESET[BIT_FAR_FAULT];
		end else if (neg_restart_i) begin
			partner_far_fault <= ABILITY_RESET[BIT_FAR_FAULT];
		end else if (ability_load) begin
			partner_far_fault <= partner_word_i[BIT_FAR_FAULT]; // [RULE4]
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			partner_pause_cap <= ABILITY_RESET[BIT_PAUSE];
		end else if (neg_restart_i) begin
			partner_pause_cap <= ABILITY_RESET[BIT_PAUSE];
		end else if (ability_load) begin
			partner_pause_cap <= partner_word_i[BIT_PAUSE]; // [RULE5]
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			partner_tech <= ABILITY_RESET[TECH_HI:TECH_LO];
		end else if (neg_restart_i) begin
			partner_tech <= ABILITY_RESET[TECH_HI:TECH_LO]; // [RULE6]
		end else if (ability_load) begin
			partner_tech <= partner_word_i[TECH_HI:TECH_LO]; // [RULE6]
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			partner_selector <= ABILITY_RESET[SEL_HI:0];
		end else if (neg_restart_i) begin
			partner_selector <= ABILITY_RESET[SEL_HI:0]; // [RULE7]
		end else if (ability_load) begin
			partner_selector <= partner_word_i[SEL_HI:0]; // [RULE7]
		end
	end

	// reserved bits 12:11 always read zero
	assign partner_ability = {partner_more_pages, partner_ack_flag, partner_far_fault, ABILITY_RESET[12:11],
		partner_pause_cap, partner_tech, partner_selector};

	// set beats the clear of a read in the same cycle, so no event is lost
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			pd_fault_flag <= 1'b0;
		end else if (pd_fault_i) begin
			pd_fault_flag <= 1'b1; // [RULE8]
		end else if (exp_read) begin
			pd_fault_flag <= 1'b0; // [RULE21]
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			page_rx_flag <= 1'b0;
		end else if (page_rx_i) begin
			// a page landing in a read cycle stays flagged for the next read
			page_rx_flag <= 1'b1; // [RULE11]
		end else if (exp_read) begin
			page_rx_flag <= 1'b0; // [RULE21]
		end
	end

	// restart also forgets partner capability: nothing exchanged yet
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			partner_an_flag <= 1'b0;
		end else if (partner_neg_able_i) begin
			partner_an_flag <= 1'b1; // [RULE12]
		end else if (neg_restart_i) begin
			partner_an_flag <= 1'b0; // [RULE12]
		end else if (exp_read) begin
			partner_an_flag <= 1'b0; // [RULE21]
		end
	end

	always_comb begin
		// bit 2 is constant: the local side always offers extra pages
		expansion_view = 16'h0000;
		expansion_view[EXP_PD_FAULT] = pd_fault_flag;
		expansion_view[EXP_PARTNER_NP] = partner_ability[BIT_MORE_PAGES]; // [RULE9]
		expansion_view[EXP_LOCAL_NP] = EXPANSION_RESET[EXP_LOCAL_NP]; // [RULE10]
		expansion_view[EXP_PAGE_RX] = page_rx_flag;
		expansion_view[EXP_PARTNER_AN] = partner_an_flag;
	end

	// reserved bit 14 is held at zero whatever is written
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			tx_more_pages <= NEXT_PAGE_TX_RESET[BIT_MORE_PAGES]; // [RULE13]
		end else if (tx_write) begin
			tx_more_pages <= reg_wdata_i[BIT_MORE_PAGES]; // [RULE13]
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			tx_msg_page <= NEXT_PAGE_TX_RESET[BIT_MSG_PAGE]; // [RULE14]
		end else if (tx_write) begin
			tx_msg_page <= reg_wdata_i[BIT_MSG_PAGE]; // [RULE14]
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			tx_comply <= NEXT_PAGE_TX_RESET[BIT_ACK2]; // [RULE15]
		end else if (tx_write) begin
			tx_comply <= reg_wdata_i[BIT_ACK2]; // [RULE15]
		end
	end

	// any code value is taken, formatted or not
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			tx_code <= NEXT_PAGE_TX_RESET[CODE_HI:0]; // [RULE17]
		end else if (tx_write) begin
			tx_code <= reg_wdata_i[CODE_HI:0]; // [RULE17] [RULE18]
		end
	end

	assign next_page_transmit = {tx_more_pages, NEXT_PAGE_TX_RESET[14], tx_msg_page, tx_comply,
		1'h0, tx_code}; // [RULE19]

	always_ff @(posedge clock_i) begin
		// restart puts the toggle back to zero so a new exchange begins in step
		if (sys_rst_i) begin
			tx_toggle <= 1'b0;
		end else if (neg_restart_i) begin
			tx_toggle <= 1'b0;
		end else if (page_sent_i) begin
			tx_toggle <= ~sent_toggle_i; // [RULE16]
		end
	end

	// toggle is not stored in the written image, so it is merged here for both readers
	always_comb begin
		next_tx_word = next_page_transmit;
		next_tx_word[BIT_TOGGLE] = tx_toggle; // [RULE16]
	end

	always_comb begin
		next_rdata = 16'h0000;
		case (reg_addr_i)
			ADDR_PARTNER_ABILITY: begin
				next_rdata = partner_ability;
			end
			ADDR_NEG_EXPANSION: begin
				next_rdata = expansion_view; // [RULE21]
			end
			ADDR_NEXT_PAGE_TX: begin
				next_rdata = next_tx_word; // [RULE16]
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	// one pulse per read strobe, even back to back
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			next_page_tx_o <= NEXT_PAGE_TX_RESET;
		end else begin
			next_page_tx_o <= next_tx_word;
		end
	end

	// registers are written before done, so complete lags their contents by a cycle
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			neg_complete_o <= 1'b0;
		end else if (neg_restart_i) begin
			neg_complete_o <= 1'b0;
		end else if (neg_done_i) begin
			neg_complete_o <= 1'b1; // [RULE20] [RULE1]
		end
	end
endmodule

/* File: tb/autoneg_regs_props.sv */
/* assertions on the register bank ports.
   bound to the design top; one clock, sync reset. */
`timescale 1ns/10ps
module autoneg_regs_props
	import autoneg_regs_pkg::*;
(
	input wire logic clock_i, sys_rst_i, reg_rd_i, reg_wr_i, base_page_rx_i, page_rx_i,
	input wire logic neg_restart_i, pd_fault_i, neg_done_i, page_sent_i, sent_toggle_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i, partner_word_i, reg_rdata_o, next_page_tx_o,
	input wire logic reg_rvalid_o, neg_complete_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	wire rd5 = reg_rd_i && reg_addr_i == ADDR_PARTNER_ABILITY;
	wire rd6 = reg_rd_i && reg_addr_i == ADDR_NEG_EXPANSION;
	property p_rvalid; reg_rd_i |=> reg_rvalid_o; endproperty
	a_rvalid: assert property (p_rvalid) else $error("no read valid");
	property p_np; rd6 |=> reg_rdata_o[EXP_LOCAL_NP]; endproperty
	a_np: assert property (p_np) else $error("local np low");
	property p_pd; pd_fault_i ##1 rd6 |=> reg_rdata_o[EXP_PD_FAULT]; endproperty
	a_pd: assert property (p_pd) else $error("pd fault lost");
	property p_ab; base_page_rx_i && !neg_restart_i ##1 rd5 && !neg_restart_i && !base_page_rx_i && !page_rx_i
		|=> reg_rdata_o == ($past(partner_word_i, 2) & 16'hE7FF); endproperty
	a_ab: assert property (p_ab) else $error("ability word");
	property p_tog; page_sent_i && !neg_restart_i ##1 !page_sent_i && !neg_restart_i
		|=> next_page_tx_o[BIT_TOGGLE] != $past(sent_toggle_i, 2); endproperty
	a_tog: assert property (p_tog) else $error("toggle");
	property p_done; $rose(neg_complete_o) |-> $past(neg_done_i); endproperty
	a_done: assert property (p_done) else $error("early complete");
	property p_txrst; $fell(sys_rst_i) |-> next_page_tx_o == NEXT_PAGE_TX_RESET; endproperty
	a_txrst: assert property (p_txrst) else $error("tx reset");
	property p_wr; reg_wr_i && reg_addr_i == ADDR_NEXT_PAGE_TX ##1 !(reg_wr_i && reg_addr_i == ADDR_NEXT_PAGE_TX)
		|=> (next_page_tx_o & NEXT_PAGE_TX_WMASK) == ($past(reg_wdata_i, 2) & NEXT_PAGE_TX_WMASK); endproperty
	a_wr: assert property (p_wr) else $error("tx write");
endmodule
bind autoneg_partner_page_regs autoneg_regs_props chk (.*);

/* File: tb/link_partner.sv */
/* remote partner model handing received code words in.
   called by the bench just after a rising edge. */
`timescale 1ns/10ps
module link_partner (input wire logic clock_i, output logic [15:0] word_o, output logic base_o, page_o, able_o);
	initial {word_o, base_o, page_o, able_o} = 0;
	task send(input logic [15:0] w, input logic nxt);
		word_o = w;
		base_o = !nxt;
		page_o = nxt;
		able_o = 1;
		@(posedge clock_i) #1;
		// stale word is inverted so it cannot pass as valid
		word_o = ~w;
		{base_o, page_o, able_o} = 0;
	endtask
endmodule

/* File: tb/autoneg_partner_page_regs_tb.sv */
/* bench for the register bank with a reference model.
   needs the checker and the partner model. */
`timescale 1ns/10ps
module autoneg_partner_page_regs_tb import autoneg_regs_pkg::*;;
	logic clock_i = 0, sys_rst_i = 1, rd = 0, wr = 0, rs = 0, pf = 0, dn = 0, ps = 0, st = 0, rv, nc, bp, pr, pa;
	logic [4:0] ad = 0;
	logic [15:0] wd = 0, w, tx = 16'h2001, rdat, ntx, pw;
	int n_fail = 0, samples_checked = 0, cyc = 0;
	initial forever #2.5 clock_i = ~clock_i;
	autoneg_partner_page_regs dut (.clock_i, .sys_rst_i, .reg_addr_i(ad), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv), .neg_restart_i(rs), .base_page_rx_i(bp),
		.partner_word_i(pw), .page_rx_i(pr), .partner_neg_able_i(pa), .pd_fault_i(pf), .neg_done_i(dn),
		.page_sent_i(ps), .sent_toggle_i(st), .next_page_tx_o(ntx), .neg_complete_o(nc));
	link_partner lp (.clock_i, .word_o(pw), .base_o(bp), .page_o(pr), .able_o(pa));
	task give_verdict;
		if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 1000) begin
			n_fail++;
			give_verdict;
		end
	end
	task step; @(posedge clock_i) #1; endtask
	task chk(input string n, input logic [15:0] g, e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task rc(input logic [4:0] a, input logic [15:0] e);
		ad = a;
		rd = 1;
		step;
		rd = 0;
		chk("rdata", rdat, e);
		step;
	endtask
	initial begin
		void'($urandom(32'h6cf7));
		repeat (16) @(posedge clock_i);
		#1 sys_rst_i = 0;
		rc(7, tx);
		rc(5, 0);
		rc(6, 4);
		w = 16'($urandom);
		lp.send(w, 0);
		rc(5, w & 16'hE7FF);
		rc(6, {12'h0, w[15], 3'b101});
		rc(6, {12'h0, w[15], 3'b100});
		w = 16'($urandom);
		lp.send(w, 1);
		pf = 1;
		step;
		pf = 0;
		rc(6, {12'h001, w[15], 3'b111});
		rc(6, {12'h0, w[15], 3'b100});
		for (int i = 0; i < 4; i++) begin
			wd = 16'($urandom);
			{ad, wr, ps, st} = {5'h07, 2'b11, i[0]};
			tx = (wd & 16'hB7FF) | {4'h0, !i[0], 11'h0};
			step;
			{wr, ps} = 0;
			step;
			chk("tx", ntx, tx);
			rc(7, tx);
		end
		ad = 5;
		wr = 1;
		step;
		wr = 0;
		rc(5, w & 16'hE7FF);
		rc(3, 0);
		rs = 1;
		step;
		rs = 0;
		rc(5, 0);
		dn = 1;
		step;
		dn = 0;
		step;
		chk("done", {15'h0, nc}, 16'h0001);
		give_verdict;
	end
endmodule
